// ---- common/xcr_defines.svh ----
// register map, field positions and limits of the call router
`ifndef XCR_DEFINES_SVH
`define XCR_DEFINES_SVH
`define XCR_OFF_CTRL     8'h00
`define XCR_OFF_STATUS   8'h04
`define XCR_OFF_ADDR_LO  8'h08
`define XCR_OFF_ADDR_HI  8'h0C
`define XCR_OFF_BASE     8'h10
`define XCR_OFF_PORT_DIS 8'h14
`define XCR_OFF_FLOW     8'h18
`define XCR_OFF_POOL     8'h1C
`define XCR_OFF_RNG0     8'h20
`define XCR_OFF_LUG0     8'h30
`define XCR_OFF_BUSY     8'h40
`define XCR_CTRL_DCE     0
`define XCR_CTRL_BASEX   1
`define XCR_CTRL_LCN0    2
`define XCR_CTRL_LUG_LSB 4
`define XCR_RNG_HI_LSB   16
`define XCR_RNG_EN       31
`define XCR_POOL_EN      8
`define XCR_TEST_REL     8'h11
`define XCR_MAX_VC       13'h005F
`define XCR_MAX_PVC      13'h0010
`define XCR_THR_MIN      4'h3
`define XCR_THR_MAX      4'hB
`define XCR_WIN_MIN      3'h1
`define XCR_WIN_MAX      3'h7
`define XCR_DIGIT_MAX    4'h9
`define XCR_FLOW_RST     14'h2ED2
`endif

// ---- common/xcr_pkg.sv ----
// types shared by the call router and its bench
package xcr_pkg;
    typedef enum logic [0:0] {XCR_IDLE = 1'b0, XCR_SRCH = 1'b1} xcr_state_e;
    typedef enum logic [2:0] {
        XCR_OK = 3'h0, XCR_NOCFG = 3'h1, XCR_NOSUB = 3'h2, XCR_BARRED = 3'h3,
        XCR_BUSY = 3'h4, XCR_NOCHAN = 3'h5, XCR_BADLCN = 3'h6
    } xcr_cause_e;
    typedef struct packed {
        logic        outgoing;
        logic [3:0]  port;
        logic        sub_present;
        logic [7:0]  sub;
        logic [31:0] caller;
        logic [11:0] lcn;
    } xcr_call_s;
    typedef struct packed {
        logic        accept;
        logic [4:0]  port;
        logic [11:0] lcn;
        xcr_cause_e  cause;
    } xcr_res_s;
    typedef struct packed {
        logic [3:0] thr_in, thr_out;
        logic [2:0] win_in, win_out;
    } xcr_flow_s;
    typedef struct packed {
        logic        en;
        logic [11:0] lo, hi;
    } xcr_range_s;
endpackage

// ---- hdl/xcr_router.sv ----
// call routing, port selection and channel allocation for a sixteen-port packet multiplexer
`timescale 1ns/1ps
`default_nettype none
`include "xcr_defines.svh"
module xcr_router
    import xcr_pkg::*;
#(
    parameter int LUG_NUM = 4
) (
    input  wire logic        core_clk,
    input  wire logic        rst_b,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output var  logic [31:0] reg_rdata,
    input  wire logic        call_req,
    input  wire xcr_call_s   call,
    input  wire logic        clr_req,
    input  wire logic [11:0] clr_lcn,
    output var  logic        res_valid,
    output var  xcr_res_s    res,
    output var  xcr_flow_s   flow_cfg,
    output var  logic        cfg_ok,
    output var  logic [16:0] port_busy
);
    localparam int NSLOT = 17;

    if (LUG_NUM < 1 || LUG_NUM > 4) begin : g_chk
        $error("LUG_NUM must lie between 1 and 4");
    end

    logic [7:0]  ctrl_reg;
    logic [31:0] addr_lo_reg;
    logic [27:0] addr_hi_reg;
    logic [7:0]  base_reg;
    logic [15:0] dis_reg;
    xcr_flow_s   flow_reg;
    logic [8:0]  pool_reg;
    xcr_range_s  rng_reg [4];
    logic [31:0] lug_reg [LUG_NUM];
    logic        cfg_ok_reg;
    logic        cfg_err_reg;
    logic [31:0] rdata_reg;
    xcr_state_e  st_reg;
    logic        phase_reg;
    logic [11:0] cand_reg;
    logic [4:0]  pend_port_reg;
    logic        res_valid_reg;
    xcr_res_s    res_reg;
    logic [16:0] busy_reg;
    logic        slot_act_reg [NSLOT];
    logic [11:0] slot_lcn_reg [NSLOT];

    logic        dce;
    logic        lcn0_ok;
    logic [7:0]  base_eff;
    logic [7:0]  sub_bin;
    logic [7:0]  base_bin;
    logic [7:0]  rel;
    logic [12:0] tot;
    logic [12:0] pvc_cnt;
    logic [11:0] prev_hi;
    logic        seen;
    logic        cfg_valid;
    logic [16:0] cand_hit;
    logic [16:0] given_hit;
    logic [16:0] clr_hit;
    logic [16:0] busy_v;
    logic [15:0] pvc_bind;
    logic [LUG_NUM-1:0] lug_hit;
    logic        pool_hit;
    logic [3:0]  pool_port;
    logic        dec_fail;
    xcr_cause_e  dec_cause;
    logic [4:0]  dec_port;
    logic        dec_search;
    xcr_range_s  rng_first;
    xcr_range_s  rng_cur;
    logic [11:0] cur_end;
    logic        fin;
    logic        fin_acc;
    logic [4:0]  fin_port;
    logic [11:0] fin_lcn;
    xcr_cause_e  fin_cause;
    logic        go_srch;
    logic        go_phase;
    logic        go_next;

    function automatic logic [7:0] bcd2bin(input logic [7:0] b);
        return {1'b0, b[7:4], 3'b000} + {3'b000, b[7:4], 1'b0} + {4'h0, b[3:0]};
    endfunction

    function automatic logic [12:0] rsize(input xcr_range_s r);
        return r.en ? ({1'b0, r.hi} - {1'b0, r.lo} + 13'h0001) : 13'h0000;
    endfunction

    function automatic logic in_rng(input xcr_range_s r, input logic [11:0] n);
        return r.en && n >= r.lo && n <= r.hi;
    endfunction

    function automatic logic [11:0] rstart(input xcr_range_s r, input logic up);
        return up ? r.lo : r.hi;
    endfunction

    assign dce      = ctrl_reg[`XCR_CTRL_DCE];
    assign lcn0_ok  = ctrl_reg[`XCR_CTRL_LCN0];
    // the two low address digits double as base when none is set apart
    assign base_eff = ctrl_reg[`XCR_CTRL_BASEX] ? base_reg : addr_lo_reg[7:0];
    assign sub_bin  = bcd2bin(call.sub);
    assign base_bin = bcd2bin(base_eff);
    assign rel      = sub_bin - base_bin;
    assign pvc_cnt  = rsize(rng_reg[0]);

    // register writes
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            ctrl_reg    <= 8'h00;
            addr_lo_reg <= 32'h0;
            addr_hi_reg <= 28'h0;
            base_reg    <= 8'h00;
            dis_reg     <= 16'h0000;
            flow_reg    <= `XCR_FLOW_RST;
            pool_reg    <= 9'h000;
            for (int r = 0; r < 4; r++) begin
                rng_reg[r] <= '0;
            end
            for (int l = 0; l < LUG_NUM; l++) begin
                lug_reg[l] <= 32'h0;
            end
        end else if (reg_wr) begin
            case (reg_addr)
                `XCR_OFF_CTRL:     ctrl_reg    <= reg_wdata[7:0];
                `XCR_OFF_ADDR_LO:  addr_lo_reg <= reg_wdata;
                `XCR_OFF_ADDR_HI:  addr_hi_reg <= reg_wdata[27:0];
                `XCR_OFF_BASE:     base_reg    <= reg_wdata[7:0];
                `XCR_OFF_PORT_DIS: dis_reg     <= reg_wdata[15:0];
                `XCR_OFF_FLOW:     flow_reg    <= {reg_wdata[3:0], reg_wdata[7:4], reg_wdata[10:8], reg_wdata[14:12]};
                `XCR_OFF_POOL:     pool_reg    <= reg_wdata[8:0];
                default: begin
                    for (int r = 0; r < 4; r++) begin
                        if (reg_addr == `XCR_OFF_RNG0 + 8'(4 * r)) begin
                            rng_reg[r] <= {reg_wdata[`XCR_RNG_EN], reg_wdata[11:0], reg_wdata[27:16]};
                        end
                    end
                    for (int l = 0; l < LUG_NUM; l++) begin
                        if (reg_addr == `XCR_OFF_LUG0 + 8'(4 * l)) begin
                            lug_reg[l] <= reg_wdata;
                        end
                    end
                end
            endcase
        end
    end

    // configuration checks applied when software commits
    always_comb begin
        cfg_valid = 1'b1;
        tot       = 13'h0000;
        prev_hi   = 12'h000;
        seen      = 1'b0;
        for (int d = 0; d < 8; d++) begin
            if (addr_lo_reg[4*d +: 4] > `XCR_DIGIT_MAX) cfg_valid = 1'b0;
        end
        for (int d = 0; d < 7; d++) begin
            if (addr_hi_reg[4*d +: 4] > `XCR_DIGIT_MAX) cfg_valid = 1'b0;
        end
        if (base_eff[7:4] > `XCR_DIGIT_MAX || base_eff[3:0] > `XCR_DIGIT_MAX) cfg_valid = 1'b0;
        if (flow_reg.thr_in < `XCR_THR_MIN || flow_reg.thr_in > `XCR_THR_MAX) cfg_valid = 1'b0;
        if (flow_reg.thr_out < `XCR_THR_MIN || flow_reg.thr_out > `XCR_THR_MAX) cfg_valid = 1'b0;
        if (flow_reg.win_in < `XCR_WIN_MIN || flow_reg.win_out < `XCR_WIN_MIN) cfg_valid = 1'b0;
        for (int r = 0; r < 4; r++) begin
            if (rng_reg[r].en) begin
                if (rng_reg[r].lo > rng_reg[r].hi) cfg_valid = 1'b0;
                if (rng_reg[r].lo == 12'h000 && !lcn0_ok) cfg_valid = 1'b0;
                if (seen && rng_reg[r].lo <= prev_hi) cfg_valid = 1'b0;
                seen    = 1'b1;
                prev_hi = rng_reg[r].hi;
                tot     = tot + rsize(rng_reg[r]);
            end
        end
        if (tot == 13'h0000) cfg_valid = 1'b0;
        if (tot > `XCR_MAX_VC || pvc_cnt > `XCR_MAX_PVC) cfg_valid = 1'b0;
        if (pool_reg[`XCR_POOL_EN] && pool_reg[3:0] > pool_reg[7:4]) cfg_valid = 1'b0;
    end

    // any configuration write takes the router out of service until recommitted
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            cfg_ok_reg  <= 1'b0;
            cfg_err_reg <= 1'b0;
        end else if (reg_wr && reg_addr == `XCR_OFF_STATUS) begin
            cfg_ok_reg  <= cfg_valid;
            cfg_err_reg <= !cfg_valid;
        end else if (reg_wr) begin
            cfg_ok_reg  <= 1'b0;
        end
    end

    // register reads: data stand one cycle after the strobe, zero otherwise
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            rdata_reg <= 32'h0;
        end else if (reg_rd) begin
            rdata_reg <= 32'h0;
            case (reg_addr)
                `XCR_OFF_CTRL:     rdata_reg <= {24'h0, ctrl_reg};
                `XCR_OFF_STATUS:   rdata_reg <= {30'h0, cfg_err_reg, cfg_ok_reg};
                `XCR_OFF_ADDR_LO:  rdata_reg <= addr_lo_reg;
                `XCR_OFF_ADDR_HI:  rdata_reg <= {4'h0, addr_hi_reg};
                `XCR_OFF_BASE:     rdata_reg <= {24'h0, base_reg};
                `XCR_OFF_PORT_DIS: rdata_reg <= {16'h0, dis_reg};
                `XCR_OFF_FLOW:     rdata_reg <= {17'h0, flow_reg.win_out, 1'b0, flow_reg.win_in,
                                                 flow_reg.thr_out, flow_reg.thr_in};
                `XCR_OFF_POOL:     rdata_reg <= {23'h0, pool_reg};
                `XCR_OFF_BUSY:     rdata_reg <= {15'h0, busy_reg};
                default: begin
                    for (int r = 0; r < 4; r++) begin
                        if (reg_addr == `XCR_OFF_RNG0 + 8'(4 * r)) begin
                            rdata_reg <= {rng_reg[r].en, 3'h0, rng_reg[r].hi, 4'h0, rng_reg[r].lo};
                        end
                    end
                    for (int l = 0; l < LUG_NUM; l++) begin
                        if (reg_addr == `XCR_OFF_LUG0 + 8'(4 * l)) begin
                            rdata_reg <= lug_reg[l];
                        end
                    end
                end
            endcase
        end else begin
            rdata_reg <= 32'h0;
        end
    end

    // caller group: the tail of the calling address against each enabled entry
    for (genvar l = 0; l < LUG_NUM; l++) begin : g_lug
        assign lug_hit[l] = ctrl_reg[`XCR_CTRL_LUG_LSB + l] && lug_reg[l] == call.caller;
    end

    // one slot per device port plus the test port bounds the active circuits
    for (genvar s = 0; s < NSLOT; s++) begin : g_slot
        assign cand_hit[s]  = slot_act_reg[s] && slot_lcn_reg[s] == cand_reg;
        assign given_hit[s] = slot_act_reg[s] && slot_lcn_reg[s] == call.lcn;
        assign clr_hit[s]   = clr_req && slot_act_reg[s] && slot_lcn_reg[s] == clr_lcn;
        if (s < 16) begin : g_pvc
            // permanent circuit k sits on port k with channel lo+k, up without any setup
            assign pvc_bind[s] = cfg_ok_reg && rng_reg[0].en && 13'(s) < pvc_cnt;
            assign busy_v[s]   = slot_act_reg[s] || pvc_bind[s];
        end else begin : g_test
            assign busy_v[s] = slot_act_reg[s];
        end
        always_ff @(posedge core_clk or negedge rst_b) begin
            if (!rst_b) begin
                slot_act_reg[s] <= 1'b0;
                slot_lcn_reg[s] <= 12'h000;
            end else begin
                if (clr_hit[s]) slot_act_reg[s] <= 1'b0;
                if (fin && fin_acc && fin_port == 5'(s)) begin
                    slot_act_reg[s] <= 1'b1;
                    slot_lcn_reg[s] <= fin_lcn;
                end
            end
        end
    end

    // lowest eligible port wins, in A1..D4 order
    always_comb begin
        pool_hit  = 1'b0;
        pool_port = 4'h0;
        for (int k = 15; k >= 0; k--) begin
            if (pool_reg[`XCR_POOL_EN] && k >= int'(pool_reg[3:0]) && k <= int'(pool_reg[7:4])
                && !busy_v[k] && !dis_reg[k]) begin
                pool_hit  = 1'b1;
                pool_port = 4'(k);
            end
        end
    end

    // decision on a new call
    always_comb begin
        dec_fail   = 1'b0;
        dec_cause  = XCR_OK;
        dec_port   = 5'h00;
        dec_search = 1'b0;
        if (!cfg_ok_reg) begin
            dec_fail  = 1'b1;
            dec_cause = XCR_NOCFG;
        end else if (call.outgoing) begin
            dec_port = {1'b0, call.port};
            if (dis_reg[call.port] || busy_v[call.port]) begin
                dec_fail  = 1'b1;
                dec_cause = XCR_BUSY;
            end else begin
                dec_search = 1'b1;
            end
        end else if ((|(ctrl_reg[`XCR_CTRL_LUG_LSB +: LUG_NUM])) && !(|lug_hit)) begin
            dec_fail  = 1'b1;
            dec_cause = XCR_BARRED;
        end else begin
            if (!call.sub_present || (base_eff == 8'h00 && call.sub == 8'h00)
                || (sub_bin >= base_bin && rel == 8'h00)) begin
                dec_port = {1'b0, pool_port};
                if (!pool_hit) begin
                    dec_fail  = 1'b1;
                    dec_cause = XCR_BUSY;
                end
            end else if (sub_bin > base_bin && rel <= 8'h10) begin
                dec_port = 5'(rel - 8'h01);
                if (dis_reg[dec_port[3:0]] || busy_v[dec_port[3:0]]) begin
                    dec_fail  = 1'b1;
                    dec_cause = XCR_BUSY;
                end
            end else if (sub_bin > base_bin && rel == `XCR_TEST_REL) begin
                dec_port = 5'h10;
                if (busy_v[16]) begin
                    dec_fail  = 1'b1;
                    dec_cause = XCR_BUSY;
                end
            end else begin
                dec_fail  = 1'b1;
                dec_cause = XCR_NOSUB;
            end
            // the far end picked the channel; it must be free and in the category it may use
            if (!dec_fail && ((dce ? !in_rng(rng_reg[3], call.lcn) : !in_rng(rng_reg[1], call.lcn))
                && !in_rng(rng_reg[2], call.lcn) || (|given_hit)
                || (call.lcn == 12'h000 && !lcn0_ok))) begin
                dec_fail  = 1'b1;
                dec_cause = XCR_BADLCN;
            end
        end
    end

    // local calls: terminal searches out then two-way downward, network side in then two-way upward
    assign rng_first = dce ? rng_reg[1] : rng_reg[3];
    assign rng_cur   = phase_reg ? rng_reg[2] : rng_first;
    assign cur_end   = rstart(rng_cur, !dce);

    always_comb begin
        fin       = 1'b0;
        fin_acc   = 1'b0;
        fin_port  = pend_port_reg;
        fin_lcn   = cand_reg;
        fin_cause = XCR_OK;
        go_srch   = 1'b0;
        go_phase  = 1'b0;
        go_next   = 1'b0;
        unique case (st_reg)
            XCR_IDLE: begin
                if (call_req) begin
                    fin_port = dec_port;
                    fin_lcn  = call.lcn;
                    if (dec_fail) begin
                        fin       = 1'b1;
                        fin_cause = dec_cause;
                    end else if (!dec_search) begin
                        fin     = 1'b1;
                        fin_acc = 1'b1;
                    end else if (rng_first.en || rng_reg[2].en) begin
                        go_srch = 1'b1;
                    end else begin
                        fin       = 1'b1;
                        fin_cause = XCR_NOCHAN;
                    end
                end
            end
            XCR_SRCH: begin
                if (!(|cand_hit)) begin
                    fin     = 1'b1;
                    fin_acc = 1'b1;
                end else if (cand_reg != cur_end) begin
                    go_next = 1'b1;
                end else if (!phase_reg && rng_reg[2].en) begin
                    go_phase = 1'b1;
                end else begin
                    fin       = 1'b1;
                    fin_cause = XCR_NOCHAN;
                end
            end
        endcase
    end

    // channel search walk, one candidate per cycle
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            st_reg        <= XCR_IDLE;
            phase_reg     <= 1'b0;
            cand_reg      <= 12'h000;
            pend_port_reg <= 5'h00;
        end else if (go_srch) begin
            st_reg        <= XCR_SRCH;
            pend_port_reg <= dec_port;
            phase_reg     <= !rng_first.en;
            cand_reg      <= rstart(rng_first.en ? rng_first : rng_reg[2], dce);
        end else if (go_next) begin
            cand_reg <= dce ? cand_reg + 12'h001 : cand_reg - 12'h001;
        end else if (go_phase) begin
            phase_reg <= 1'b1;
            cand_reg  <= rstart(rng_reg[2], dce);
        end else if (fin) begin
            st_reg <= XCR_IDLE;
        end
    end

    // answer and busy view
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            res_valid_reg <= 1'b0;
            res_reg       <= '0;
            busy_reg      <= 17'h00000;
        end else begin
            res_valid_reg <= fin;
            busy_reg      <= busy_v;
            if (fin) begin
                res_reg <= '{accept: fin_acc, port: fin_port, lcn: fin_acc ? fin_lcn : 12'h000, cause: fin_cause};
            end
        end
    end

    assign reg_rdata = rdata_reg;
    assign res_valid = res_valid_reg;
    assign res       = res_reg;
    assign flow_cfg  = flow_reg;
    assign cfg_ok    = cfg_ok_reg;
    assign port_busy = busy_reg;
endmodule
`default_nettype wire

// ---- test/xcr_net_model.sv ----
// far-end network model: offers calls and clears to the router
`timescale 1ns/1ps
`default_nettype none
module xcr_net_model
    import xcr_pkg::*;
(
    input wire logic        core_clk,
    output var logic        call_req,
    output var xcr_call_s   call,
    output var logic        clr_req,
    output var logic [11:0] clr_lcn
);
    initial begin
        call_req = 1'b0;
        clr_req = 1'b0;
        call = '1;
        clr_lcn = '1;
    end
    // the lcn is driven as given in the call handed in; the model picks none itself
    task automatic place(input xcr_call_s c);
        @(posedge core_clk);
        call_req <= 1'b1;
        call <= c;
        @(posedge core_clk);
        call_req <= 1'b0;
        call <= ~c; // released lines must not keep the last value
    endtask
    task automatic clear(input logic [11:0] l);
        @(posedge core_clk);
        clr_req <= 1'b1;
        clr_lcn <= l;
        @(posedge core_clk);
        clr_req <= 1'b0;
        clr_lcn <= ~l;
    endtask
endmodule
`default_nettype wire

// ---- test/xcr_router_bench.sv ----
// self-checking bench for the call router
`timescale 1ns/1ps
`default_nettype none
module xcr_router_bench;
    import xcr_pkg::*;
    logic        core_clk = 1'b0, rst_b = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
    logic [7:0]  reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0, reg_rdata;
    logic        call_req, clr_req, res_valid, cfg_ok;
    logic [11:0] clr_lcn;
    logic [16:0] port_busy;
    xcr_call_s   call;
    xcr_res_s    res;
    xcr_flow_s   flow_cfg;
    int          failures = 0, n_compared = 0;
    always #4 core_clk = ~core_clk;
    xcr_router xcr_router_i (.*);
    xcr_net_model xcr_net_model_i (.*);
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic summarize;
        $display("mismatches=%0d compared=%0d", failures, n_compared);
        if (failures == 0 && n_compared > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic rst;
        rst_b <= 1'b0;
        repeat (10) @(posedge core_clk);
        rst_b <= 1'b1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge core_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata, e);
    endtask
    // base comes from the last two address digits (40); IN 1-2, two-way 3-4, OUT 5-6, pool A1..A4
    task automatic cfg(input logic [31:0] ctrl, input logic [31:0] dis, input logic [31:0] flow);
        wr(8'h00, ctrl);
        wr(8'h30, 32'h0000_1234);
        wr(8'h14, dis);
        wr(8'h08, 32'h0975_4340);
        wr(8'h18, flow);
        wr(8'h1C, 32'h0000_0130);
        wr(8'h24, 32'h8002_0001);
        wr(8'h28, 32'h8004_0003);
        wr(8'h2C, 32'h8006_0005);
        wr(8'h04, 32'h0);
    endtask
    function automatic xcr_call_s inc(logic [7:0] s, logic [11:0] l, logic [31:0] c = 32'h1234);
        return '{1'b0, 4'h0, s != 8'hFF, s, c, l};
    endfunction
    function automatic xcr_call_s loc(logic [3:0] p);
        return '{1'b1, p, 1'b0, 8'h00, 32'h0, 12'h000};
    endfunction
    function automatic xcr_res_s acc(logic [4:0] p, logic [11:0] l);
        return '{1'b1, p, l, XCR_OK};
    endfunction
    function automatic xcr_res_s rej(xcr_cause_e c);
        return '{1'b0, 5'h0, 12'h000, c};
    endfunction
    // the refused answer still carries the decoded port, so it is masked out
    task automatic pl(input xcr_call_s c, input xcr_res_s e);
        xcr_net_model_i.place(c);
        // look at the answer mid-cycle, where it is settled
        for (int i = 0; i < 200 && res_valid !== 1'b1; i++)
            @(negedge core_clk);
        if (res_valid !== 1'b1) failures++;
        chk(32'({res.accept, res.accept ? res.port : 5'h0, res.lcn, res.cause}), 32'(e));
    endtask
    task automatic s_reset;
        rst();
        chk(32'(flow_cfg), 32'h2ED2);
        pl(inc(8'h41, 12'h001), rej(XCR_NOCFG));
        rd(8'h7C, 32'h0);
    endtask
    task automatic s_route;
        cfg(32'h0, 32'h0, 32'h20BB);
        rd(8'h04, 32'h2);
        wr(8'h18, 32'h22BB);
        wr(8'h04, 32'h0);
        rd(8'h04, 32'h1);
        pl(inc(8'h41, 12'h001), acc(5'd0, 12'h001));
        pl(inc(8'h57, 12'h002), acc(5'd16, 12'h002));
        pl(inc(8'h41, 12'h003), rej(XCR_BUSY));
        pl(inc(8'h39, 12'h003), rej(XCR_NOSUB));
        pl(inc(8'hFF, 12'h003), acc(5'd1, 12'h003));
        pl(inc(8'h40, 12'h004), acc(5'd2, 12'h004));
        pl(inc(8'h45, 12'h005), rej(XCR_BADLCN));
    endtask
    task automatic s_alloc;
        pl(loc(4'd3), acc(5'd3, 12'h006));
        pl(loc(4'd4), acc(5'd4, 12'h005));
        pl(loc(4'd5), rej(XCR_NOCHAN));
        xcr_net_model_i.clear(12'h006);
        pl(loc(4'd5), acc(5'd5, 12'h006));
        rd(8'h40, 32'h10037);
    endtask
    task automatic s_restrict;
        rst();
        cfg(32'h11, 32'h40, 32'h22BB);
        pl(loc(4'd0), acc(5'd0, 12'h001));
        pl(loc(4'd6), rej(XCR_BUSY));
        pl(inc(8'h42, 12'h005, 32'h9), rej(XCR_BARRED));
        pl(inc(8'h42, 12'h005), acc(5'd1, 12'h005));
        pl(inc(8'h47, 12'h006), rej(XCR_BUSY));
    endtask
    // explicit base 20 and one permanent circuit on channel 0, bound to port A1
    task automatic s_pvc;
        rst();
        cfg(32'h02, 32'h0, 32'h22BB);
        wr(8'h10, 32'h20);
        wr(8'h20, 32'h8000_0000);
        wr(8'h04, 32'h0);
        rd(8'h04, 32'h2);
        wr(8'h00, 32'h06);
        wr(8'h04, 32'h0);
        rd(8'h04, 32'h1);
        rd(8'h40, 32'h1);
        pl(inc(8'h21, 12'h001), rej(XCR_BUSY));
        pl(inc(8'h22, 12'h001), acc(5'h01, 12'h001));
    endtask
    initial begin
        s_reset();
        s_route();
        s_alloc();
        s_restrict();
        s_pvc();
        summarize();
    end
    // about seventy-five times the expected run length
    initial begin
        #100000;
        failures++;
        summarize();
    end
endmodule
`default_nettype wire

// ---- test/xcr_router_checker.sv ----
// assertions on the call router ports
`timescale 1ns/1ps
`default_nettype none
module xcr_router_checker
    import xcr_pkg::*;
(
    input wire logic        core_clk,
    input wire logic        rst_b,
    input wire logic [7:0]  reg_addr,
    input wire logic        reg_wr,
    input wire logic        call_req,
    input wire logic        res_valid,
    input wire xcr_res_s    res,
    input wire xcr_flow_s   flow_cfg,
    input wire logic        cfg_ok,
    input wire logic [16:0] port_busy
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_b);
    chk_thr_class: assert property (cfg_ok |-> flow_cfg.thr_in inside {[4'h3:4'hB]}
        && flow_cfg.thr_out inside {[4'h3:4'hB]}) else $error("throughput class out of range");
    chk_win_size: assert property (cfg_ok |-> flow_cfg.win_in != 3'h0 && flow_cfg.win_out != 3'h0)
        else $error("window size zero");
    chk_cfg_drop: assert property (reg_wr && reg_addr != 8'h04 |=> !cfg_ok)
        else $error("config kept after edit");
    chk_nocfg_cause: assert property (call_req && !cfg_ok |=> res_valid && res.cause == XCR_NOCFG)
        else $error("call before commit not refused");
    chk_refuse_form: assert property (res_valid && !res.accept |-> res.lcn == 12'h0 && res.cause != XCR_OK)
        else $error("refusal malformed");
    chk_grant_form: assert property (res_valid && res.accept |-> res.port <= 5'd16 && res.cause == XCR_OK)
        else $error("grant malformed");
    chk_grant_busy: assert property (res_valid && res.accept |=> port_busy[$past(res.port)])
        else $error("granted port not busy");
    chk_test_grant: assert property ($rose(port_busy[16]) |-> $past(res_valid) && $past(res.port) == 5'd16)
        else $error("test port busy without grant");
    cover property (res_valid && res.accept);
    cover property (res_valid && res.cause == XCR_NOCHAN);
    cover property ($rose(cfg_ok));
endmodule
bind xcr_router xcr_router_checker xcr_router_checker_i (.*);
`default_nettype wire
